// ### rtl/sar_adc_parallel_host_port.sv
// Conversion control and parallel host port of a six-channel sampler.
// Assumes all pins synchronous to sys_clk_i; converter results on result_data_i.
`default_nettype none
`include "adc_port_regs.svh"

module sar_adc_parallel_host_port (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Conversion starts, active-low pulses
	input wire logic start_pair_one_i,
	input wire logic start_pair_two_i,
	input wire logic start_pair_three_i,
	// Mode pins
	input wire logic interface_choice_pin_i,
	input wire logic word_byte_sel_i,
	input wire logic hw_sw_sel_i,
	// Host strobes, active low
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	// Data bus as three signals
	input wire logic [`WORD_W-1:0] db_i,
	output logic [`WORD_W-1:0] db_o,
	output logic [`WORD_W-1:0] db_oe_n_o,
	// Converter side
	input wire logic [`RES_W-1:0] result_data_i,
	output logic [`RES_W-1:0] result_words_o,
	output logic busy_o,
	output logic [`NUM_PAIRS-1:0] track_hold_o,
	output logic [`NUM_PAIRS-1:0] pair_range_o,
	output logic internal_reference_on_o,
	output logic reference_buffer_off_o
);
	// ****************************************
	// Declarations
	// ****************************************
	adc_port_pkg::port_state_t st_r, st_nxt;
	conv_if cv ();
	logic [`NUM_PAIRS-1:0] start_now;
	logic [`NUM_PAIRS-1:0] rise;
	logic [`NUM_PAIRS-1:0] pairs;
	logic accept;
	logic rd_now;
	logic wr_now;
	logic rd_end;
	logic wr_end;
	logic [`RES_W-1:0] captured;

	// First channel at or after a point whose pair is in the mask
	function automatic logic [2:0] seek(input logic [2:0] m, input logic [2:0] from);
		logic [2:0] r;
		r = `NO_CH;
		for (int i = `NUM_CH - 1; i >= 0; i--) begin
			if (i >= int'(from) && m[i / 2]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// ****************************************
	// Conversion timer
	// ****************************************
	conv_timer u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.cv(cv.timer)
	);

	// Start edge detection and pair choice
	assign start_now = {start_pair_three_i, start_pair_two_i, start_pair_one_i};
	assign rise = start_now & ~st_r.start_prev;
	assign pairs = hw_sw_sel_i ? st_r.cfg[`CFG_SEL_MSB:`CFG_SEL_LSB] : rise;
	// Software mode listens to start one only
	assign accept = !cv.busy && (hw_sw_sel_i ? rise[0] : |rise);
	assign cv.start = accept;

	// Strobe decode; a write needs read high
	assign rd_now = !interface_choice_pin_i && !cs_n_i && !rd_n_i;
	assign wr_now = !cs_n_i && !wr_n_i && rd_n_i;
	assign rd_end = st_r.rd_act && !rd_now;
	assign wr_end = st_r.wr_act && !wr_now;

	// Per-channel capture, zero fill of unconverted pairs in serial mode
	genvar ch;
	generate
		for (ch = 0; ch < `NUM_CH; ch++) begin : g_cap
			assign captured[ch*`WORD_W +: `WORD_W] =
				(interface_choice_pin_i && !st_r.pending[ch / 2]) ? `RES_ZERO
				: result_data_i[ch*`WORD_W +: `WORD_W];
		end
	endgenerate

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [`WORD_W-1:0] word;
		logic [2:0] nxt_ch;
		logic hi_sel;
		word = `RES_ZERO;
		nxt_ch = `NO_CH;
		hi_sel = 1'b0;
		st_nxt = st_r;
		st_nxt.start_prev = start_now;
		st_nxt.rd_act = rd_now;
		st_nxt.wr_act = wr_now;
		// Pairs go to hold on an accepted start
		if (accept) begin
			st_nxt.pending = pairs;
			st_nxt.hold = pairs;
		end
		// End of conversion: tracking again, new read list
		if (cv.done) begin
			st_nxt.hold = '0;
			st_nxt.mask = st_r.pending;
			st_nxt.res = captured;
			st_nxt.ptr = seek(st_r.pending, 3'h0);
			st_nxt.phase = 1'b0;
		end else if (rd_end) begin
			// Advance after each read; byte mode steps on second byte
			if (word_byte_sel_i && !st_r.phase) begin
				st_nxt.phase = 1'b1;
			end else begin
				st_nxt.phase = 1'b0;
				nxt_ch = seek(st_r.mask, st_r.ptr + 3'h1);
				st_nxt.ptr = (nxt_ch == `NO_CH) ? seek(st_r.mask, 3'h0) : nxt_ch;
			end
		end
		// Config write lands on the rising write strobe
		if (wr_end) begin
			st_nxt.cfg = db_i[`CFG_BUS_MSB:`CFG_BUS_LSB];
		end
		// Output word follows the pointer one cycle later
		if (st_r.ptr < 3'(`NUM_CH)) begin
			word = st_r.res[st_r.ptr*`WORD_W +: `WORD_W];
		end
		hi_sel = st_r.phase ^ db_i[`BYTE_ORDER_LINE];
		if (word_byte_sel_i) begin
			st_nxt.dout = {hi_sel ? word[15:8] : word[7:0], `LOW_BYTE_ZERO};
		end else begin
			st_nxt.dout = word;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.start_prev <= '1;
			st_r.cfg <= `CFG_RESET;
			st_r.ptr <= `NO_CH;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Bus enables; low lines stay off in byte mode
	always_comb begin
		if (!rd_now) begin
			db_oe_n_o = `OE_OFF;
		end else if (word_byte_sel_i) begin
			db_oe_n_o = `OE_BYTE;
		end else begin
			db_oe_n_o = `OE_WORD;
		end
	end
	assign db_o = st_r.dout;
	assign result_words_o = st_r.res;
	assign busy_o = cv.busy;
	assign track_hold_o = st_r.hold;
	// Range and reference controls from the config
	assign pair_range_o = st_r.cfg[`CFG_RNG_MSB:`CFG_RNG_LSB];
	assign internal_reference_on_o = st_r.cfg[`CFG_INTERNAL_REFERENCE_ON_BIT];
	assign reference_buffer_off_o = st_r.cfg[`CFG_REFERENCE_BUFFER_OFF_BIT];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	AST_BUSY_PROMPT: assert property (accept |=> busy_o [*8])
		else $error("busy not raised after start");
	AST_IGNORE_BUSY: assert property (busy_o && |rise |-> !accept ##1 $stable(st_r.pending))
		else $error("start taken while busy");
	AST_TRACK_AT_END: assert property ($fell(busy_o) |-> track_hold_o == '0)
		else $error("hold kept after busy fell");
	AST_BUS_HIZ: assert property ((cs_n_i || rd_n_i) |-> db_oe_n_o == `OE_OFF)
		else $error("bus driven without select and read");
	AST_BYTE_LINES: assert property (rd_now && word_byte_sel_i |-> db_oe_n_o[7:0] == 8'hFF)
		else $error("low lines driven in byte mode");
	AST_CFG_RESET: assert property (disable iff (1'b0) rst_i |=> st_r.cfg == `CFG_RESET)
		else $error("config not cleared by reset");
	AST_CFG_WRITE: assert property (wr_end |=>
		st_r.cfg == $past(db_i[`CFG_BUS_MSB:`CFG_BUS_LSB]))
		else $error("config write lost");
	AST_SW_START: assert property (hw_sw_sel_i && accept |=>
		track_hold_o == $past(st_r.cfg[`CFG_SEL_MSB:`CFG_SEL_LSB]))
		else $error("software selection not applied");
	AST_HW_PAIR: assert property (!hw_sw_sel_i && !busy_o && rise == 3'h2 |=>
		track_hold_o == 3'h2)
		else $error("start two did not hold pair two");
	// Pair three left out of a serial conversion: its last channel word reads zero
	AST_SER_ZERO: assert property (cv.done && interface_choice_pin_i && !st_r.pending[2] |=>
		result_words_o[`RES_W-1 -: `WORD_W] == `RES_ZERO)
		else $error("unconverted channel not zero");
	AST_ORDER: assert property (rd_end && !word_byte_sel_i && !cv.done
		&& st_r.ptr == 3'h0 && st_r.mask[0] |=> st_r.ptr == 3'h1)
		else $error("read order broken");

	COV_CONV: cover property ($fell(busy_o));
	COV_BYTE_READ: cover property (rd_end && word_byte_sel_i && st_r.phase);
	COV_CFG_WRITE: cover property (wr_end);
	COV_PAIR_SKIP: cover property (cv.done && st_r.pending == 3'h5);
endmodule

`default_nettype wire

// ### rtl/adc_port_regs.svh
// Constants of the parallel host port: control layout, timing, bus values.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

// ****************************************
// Control register
// ****************************************
`define CFG_W 8
`define CFG_RESET 8'h00
`define CFG_SEL_MSB 7
`define CFG_SEL_LSB 5
`define CFG_RNG_MSB 4
`define CFG_RNG_LSB 2
`define CFG_INTERNAL_REFERENCE_ON_BIT 1
`define CFG_REFERENCE_BUFFER_OFF_BIT 0
`define CFG_BUS_MSB 15
`define CFG_BUS_LSB 8

// ****************************************
// Conversion timing
// ****************************************
`define CLK_PERIOD_NS 10
`define CONV_TIME_NS 3000
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W 9

// ****************************************
// Channels and data bus
// ****************************************
`define NUM_PAIRS 3
`define NUM_CH 6
`define WORD_W 16
`define RES_W 96
`define NO_CH 3'h7
`define BYTE_ORDER_LINE 7
`define OE_OFF 16'hFFFF
`define OE_WORD 16'h0000
`define OE_BYTE 16'h00FF
`define LOW_BYTE_ZERO 8'h00
`define RES_ZERO 16'h0000

`endif

// ### rtl/adc_port_pkg.sv
// Types of the parallel host port: the state records of both modules.
// Assumes the constant header is on the include path.
`default_nettype none
`include "adc_port_regs.svh"

package adc_port_pkg;
	// ****************************************
	// Main port state
	// ****************************************
	typedef struct packed {
		logic [`NUM_PAIRS-1:0] start_prev;
		logic [`NUM_PAIRS-1:0] pending;
		logic [`NUM_PAIRS-1:0] mask;
		logic [`NUM_PAIRS-1:0] hold;
		logic [`CFG_W-1:0] cfg;
		logic wr_act;
		logic rd_act;
		logic [2:0] ptr;
		logic phase;
		logic [`RES_W-1:0] res;
		logic [`WORD_W-1:0] dout;
	} port_state_t;

	// ****************************************
	// Conversion timer state
	// ****************************************
	typedef struct packed {
		logic busy;
		logic [`CONV_CNT_W-1:0] cnt;
	} timer_state_t;
endpackage

`default_nettype wire

// ### rtl/conv_if.sv
// Link between the port logic and the conversion timer.
// Assumes both ends share one clock.
`default_nettype none

interface conv_if;
	logic start;
	logic busy;
	logic done;
	modport ctrl (output start, input busy, input done);
	modport timer (input start, output busy, output done);
endinterface

`default_nettype wire

// ### rtl/conv_timer.sv
// Conversion timer standing in for the internal oscillator.
// Assumes start is a one-cycle pulse from the port logic.
`default_nettype none
`include "adc_port_regs.svh"

module conv_timer (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Port side
	conv_if.timer cv
);
	adc_port_pkg::timer_state_t st_r, st_nxt;

	// End of the fixed interval
	assign cv.done = st_r.busy && (st_r.cnt == `CONV_CNT_W'(`CONV_CYCLES - 1));
	assign cv.busy = st_r.busy;

	// Busy framing; starts while busy are dropped here too
	always_comb begin
		st_nxt = st_r;
		if (cv.start && !st_r.busy) begin
			st_nxt.busy = 1'b1;
			st_nxt.cnt = '0;
		end else if (cv.done) begin
			st_nxt.busy = 1'b0;
		end else if (st_r.busy) begin
			st_nxt.cnt = st_r.cnt + `CONV_CNT_W'(1);
		end
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	AST_BUSY_TIME: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(st_r.busy) |-> ##299 st_r.busy ##1 !st_r.busy)
		else $error("busy width not 3 us");
endmodule

`default_nettype wire

// ### testbench/host_bus_model.sv
// Host side of the parallel data bus: resolves each line from both drivers.
// Assumes enables change just after sys_clk rises; undriven lines float.
`default_nettype none

module host_bus_model (
	// Clock
	input wire logic clk_i,
	// Device side
	input wire logic [15:0] db_o_i,
	input wire logic [15:0] oe_n_i,
	// Host side
	input wire logic [15:0] en_i,
	input wire logic [15:0] val_i,
	// Resolved lines
	output logic [15:0] bus_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********
	// Line resolution
	// ********
	logic [15:0] last_r;
	// A floating line flips each cycle so a stale value never passes for data
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (!oe_n_i[i]) begin
				bus_o[i] = db_o_i[i];
			end else if (en_i[i]) begin
				bus_o[i] = val_i[i];
			end else begin
				bus_o[i] = ~last_r[i];
			end
		end
	end
	// Last level of every line
	always_ff @(posedge clk_i) begin
		last_r <= bus_o;
	end
endmodule

`default_nettype wire

// ### testbench/sar_adc_parallel_host_port_tb.sv
// Self-checking bench of the parallel host port: reset, config write,
// hardware, software and serial conversions, word and byte reads.
// Assumes the design files and the host bus model are compiled first.
`default_nettype none
`include "adc_port_regs.svh"

module sar_adc_parallel_host_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ********
	// Signals
	// ********
	logic clk = 0;
	logic rst = 1;
	logic ifc = 0;
	logic wb = 0;
	logic hs = 0;
	logic cs_n = 1;
	logic rd_n = 1;
	logic wr_n = 1;
	logic hi_en = 0;
	logic ho = 0;
	logic [7:0] hi_val = 8'h00;
	logic [2:0] st = 3'h7;
	logic [2:0] hold;
	logic [2:0] rng;
	logic [15:0] db_o;
	logic [15:0] oe_n;
	logic [15:0] bus;
	logic [`RES_W-1:0] res;
	logic [`RES_W-1:0] words;
	logic busy;
	logic refon;
	logic bufoff;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	// ********
	// Design and host bus
	// ********
	sar_adc_parallel_host_port dut (.sys_clk_i(clk), .rst_i(rst), .start_pair_one_i(st[0]),
		.start_pair_two_i(st[1]), .start_pair_three_i(st[2]), .interface_choice_pin_i(ifc),
		.word_byte_sel_i(wb), .hw_sw_sel_i(hs), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.db_i(bus), .db_o(db_o), .db_oe_n_o(oe_n), .result_data_i(res),
		.result_words_o(words), .busy_o(busy), .track_hold_o(hold), .pair_range_o(rng),
		.internal_reference_on_o(refon), .reference_buffer_off_o(bufoff));
	host_bus_model hb (.clk_i(clk), .db_o_i(db_o), .oe_n_i(oe_n),
		.en_i({{8{hi_en}}, wb, 7'h00}), .val_i({hi_val, ho, 7'h00}), .bus_o(bus));
	// ********
	// Clock and watchdog
	// ********
	always #5 clk = ~clk;
	// Ceiling well above the four conversions of the run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// ********
	// Tasks
	// ********
	function automatic logic [15:0] exp_word(int k);
		return 16'hC000 | (16'(k) * 16'h0111);
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_cfg(logic [7:0] v);
		cs_n = 0;
		wr_n = 0;
		hi_en = 1;
		hi_val = v;
		tick(3);
		cs_n = 1;
		wr_n = 1;
		tick(1);
		hi_en = 0;
		tick(1);
	endtask
	task automatic rd(logic [15:0] e);
		cs_n = 0;
		rd_n = 0;
		tick(2);
		chk("oe", wb ? 16'h00FF : 16'h0000, oe_n);
		chk("bus_hi", e[15:8], bus[15:8]);
		if (!wb) chk("bus_lo", e[7:0], bus[7:0]);
		cs_n = 1;
		rd_n = 1;
		tick(3);
	endtask
	// Reads every converted channel, both bytes in the chosen order
	task automatic rd_pairs(logic [2:0] m);
		logic [15:0] w;
		for (int k = 0; k < `NUM_CH; k++) begin
			w = exp_word(k);
			if (m[k/2] && !wb) rd(w);
			if (m[k/2] && wb && !ho) rd({w[7:0], 8'h00});
			if (m[k/2] && wb) rd(w);
			if (m[k/2] && wb && ho) rd({w[7:0], 8'h00});
		end
	endtask
	// Pulses the starts, re-pulses all of them mid-busy, times busy
	task automatic conv(logic [2:0] pins, logic [2:0] hexp);
		int n;
		n = 0;
		st = ~pins;
		tick(1);
		st = 3'h7;
		// Busy and hold are up one cycle after the rise; count busy from here
		tick(1);
		chk("hold", 16'(hexp), 16'(hold));
		while (busy === 1'b1 && n < 400) begin
			n++;
			st = (n >= 100 && n < 103) ? 3'h0 : 3'h7;
			tick(1);
		end
		chk("busy_len", 16'd300, 16'(n));
		chk("hold_end", 16'h0000, 16'(hold));
		tick(5);
		chk("busy_rearm", 16'h0000, 16'(busy));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ********
	// Tests
	// ********
	initial begin
		for (int k = 0; k < `NUM_CH; k++) res[16*k+:16] = exp_word(k);
		tick(10);
		rst = 0;
		tick(1);
		chk("busy_rst", 16'h0000, 16'(busy));
		chk("cfg_rst", 16'h0000, 16'({rng, refon, bufoff}));
		chk("oe_rst", 16'hFFFF, oe_n);
		$display("test reset done");
		wr_cfg(8'hAD);
		chk("cfg", 16'h000D, 16'({rng, refon, bufoff}));
		$display("test config done");
		conv(3'h5, 3'h5);
		rd_pairs(3'h5);
		$display("test word read done");
		wb = 1;
		conv(3'h2, 3'h2);
		rd_pairs(3'h2);
		ho = 1;
		rd_pairs(3'h2);
		$display("test byte read done");
		wb = 0;
		ho = 0;
		hs = 1;
		conv(3'h1, 3'h5);
		rd_pairs(3'h5);
		$display("test software select done");
		hs = 0;
		ifc = 1;
		conv(3'h1, 3'h1);
		chk("ser_ch0", exp_word(0), words[15:0]);
		for (int k = 2; k < `NUM_CH; k++) chk("ser_zero", `RES_ZERO, words[16*k+:16]);
		cs_n = 0;
		rd_n = 0;
		tick(2);
		chk("oe_ser", 16'hFFFF, oe_n);
		cs_n = 1;
		rd_n = 1;
		$display("test serial done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
